// file: ctl_defines.svh
// bit positions, reset values and timing figures of the command and decode block
`ifndef CTL_DEFINES_SVH
`define CTL_DEFINES_SVH
`define CSR_PIN 7
`define CSR_ESO 6
`define CSR_ES1 5
`define CSR_ES2 4
`define CSR_ENI 3
`define CSR_STA 2
`define CSR_STO 1
`define CSR_ACK 0
`define RST_PIN 1'b1
`define RST_BUS_FREE 1'b1
`define RST_UNINIT 1'b1
`define RST_BYTE 8'h00
`define PIN_W 13
`define PH_SCL_HIGH_FIRST 3'h2
`define PH_SAMPLE 3'h5
`define PH_SCL_LOW_AGAIN 3'h6
`define PH_LAST 3'h7
`define BIT_ACK 4'h8
`define LRST_HOLD 4'hF
`endif

// file: ctl_pkg.sv
// types shared by the command and decode block
package ctl_pkg;
  typedef enum logic [2:0] {
    sel_none,
    sel_ctrl,
    sel_own,
    sel_vec,
    sel_clk,
    sel_data
  } sel_t;
  typedef enum logic [1:0] {
    slave_receive_state,
    master_transmit_state,
    master_receive_state
  } mode_t;
  typedef enum logic [2:0] {
    l_idle,
    l_stop,
    l_start,
    l_bit,
    l_end
  } link_t;
endpackage

// file: i2c_controller_command_decode.sv
// control/status register, register-select decode and bus command engine
`timescale 1ns/10ps
`default_nettype none
`include "ctl_defines.svh"

// Summary of operation
// - writing one into pending-service clears all status flags except bus-free and the uninitialised flag
// - only pending-service reads the same in both views; other positions split into control and status
// - serial enable low: bus idle, set-up registers reachable
// - serial enable high: bus active, shift data reachable, status readable
// - enable low: pin high selects control; pin low selects own address, vector, clock
// - enable high, select1 low: pin high control/status; pin low data or vector
// - acknowledge low with select1 low puts vector on bus; ignored when interrupts off
// - enable low: control reads return interrupt enable, start, stop, acknowledge bits
// - long-distance mode: pin high control/status, pin low shift data, select2 ignored
// - clearing serial enable to reach other registers leaves long-distance mode
// - interrupt output low while interrupts enabled and pending-service is zero
// - start-only command as slave receiver sends start and address, direction picks mode
// - stop-only command as master sends stop and returns to slave receiver
// - start and stop together as master send stop, start and address
// - no start or stop, or unlisted combination, causes no bus operation
// - acknowledge bit one drives acknowledge on ninth clock after received bytes
// - control and status bit layout from pending-service down to acknowledge or bus-free
// - pending-service set on start, data write or read; cleared after each byte
// - reset clears all flags except pending-service, bus-free and the uninitialised flag, which set
module i2c_controller_command_decode (
  input wire logic clock,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic register_select_pin,
  input wire logic irq_acknowledge_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic irq_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic scl_out,
  output logic scl_oe
);

  // ----------------------------------------
  // register-select decode
  // ----------------------------------------
  function automatic ctl_pkg::sel_t decode(input logic a0, input logic serial_output_enable,
                                           input logic es1, input logic es2);
    ctl_pkg::sel_t s;
    s = ctl_pkg::sel_none;
    if (a0) begin
      s = ctl_pkg::sel_ctrl;
    end else if (serial_output_enable && es1) begin
      s = ctl_pkg::sel_data;
    end else if (serial_output_enable) begin
      s = es2 ? ctl_pkg::sel_vec : ctl_pkg::sel_data;
    end else if (!es1) begin
      s = es2 ? ctl_pkg::sel_vec : ctl_pkg::sel_own;
    end else if (!es2) begin
      s = ctl_pkg::sel_clk;
    end
    return s;
  endfunction

  // ----------------------------------------
  // host pin synchronisers
  // ----------------------------------------
  // three stages; a change counts once stages two and three agree
  logic [`PIN_W-1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_f_ff;
  always_ff @(posedge clock) begin
    pin_s1_ff <= {cs_n, rd_n, wr_n, register_select_pin, irq_acknowledge_n, data_in};
    pin_s2_ff <= pin_s1_ff;
    pin_s3_ff <= pin_s2_ff;
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_f_ff <= {5'h1F, 8'h00};
    end else begin
      for (int i = 0; i < `PIN_W; i++) begin
        if (pin_s2_ff[i] == pin_s3_ff[i]) begin
          pin_f_ff[i] <= pin_s3_ff[i];
        end
      end
    end
  end

  logic f_a0, f_irq_acknowledge_n_n;
  logic [7:0] f_data;
  logic wr_act, rd_act, wr_act_ff, rd_act_ff, wr_pulse, rd_pulse;
  assign wr_act = ~pin_f_ff[12] & ~pin_f_ff[10];
  assign rd_act = ~pin_f_ff[12] & ~pin_f_ff[11];
  assign f_a0 = pin_f_ff[9];
  assign f_irq_acknowledge_n_n = pin_f_ff[8];
  assign f_data = pin_f_ff[7:0];
  assign wr_pulse = wr_act & ~wr_act_ff;
  assign rd_pulse = rd_act & ~rd_act_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_act_ff <= 1'b0;
      rd_act_ff <= 1'b0;
    end else begin
      wr_act_ff <= wr_act;
      rd_act_ff <= rd_act;
    end
  end

  // ----------------------------------------
  // control bits and set-up registers
  // ----------------------------------------
  logic eso_ff, es1_ff, es2_ff, eni_ff, sta_ff, sto_ff, ack_ff;
  logic [7:0] own_address_ff, irq_vector_ff, clock_config_ff, shift_data_ff;
  ctl_pkg::sel_t sel;
  assign sel = decode(f_a0, eso_ff, es1_ff, es2_ff);

  always_ff @(posedge clock) begin
    if (rst) begin
      eso_ff <= 1'b0;
      es1_ff <= 1'b0;
      es2_ff <= 1'b0;
      eni_ff <= 1'b0;
      sta_ff <= 1'b0;
      sto_ff <= 1'b0;
      ack_ff <= 1'b0;
    end else if (wr_pulse && sel == ctl_pkg::sel_ctrl) begin
      // writing enable low also drops long-distance mode
      eso_ff <= f_data[`CSR_ESO];
      es1_ff <= f_data[`CSR_ES1];
      es2_ff <= f_data[`CSR_ES2];
      eni_ff <= f_data[`CSR_ENI];
      sta_ff <= f_data[`CSR_STA];
      sto_ff <= f_data[`CSR_STO];
      ack_ff <= f_data[`CSR_ACK];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      own_address_ff <= `RST_BYTE;
      irq_vector_ff <= `RST_BYTE;
      clock_config_ff <= `RST_BYTE;
    end else if (wr_pulse) begin
      if (sel == ctl_pkg::sel_own) begin
        own_address_ff <= f_data;
      end else if (sel == ctl_pkg::sel_vec) begin
        irq_vector_ff <= f_data;
      end else if (sel == ctl_pkg::sel_clk) begin
        clock_config_ff <= f_data;
      end
    end
  end

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  ctl_pkg::mode_t mode_ff;
  logic busy_ff, done_pulse;
  logic launch, l_stop, l_start, l_byte, l_rx;

  always_comb begin
    launch = 1'b0;
    l_stop = 1'b0;
    l_start = 1'b0;
    l_byte = 1'b0;
    l_rx = 1'b0;
    if (wr_pulse && sel == ctl_pkg::sel_ctrl && f_data[`CSR_ESO] && !busy_ff) begin
      case ({f_data[`CSR_STA], f_data[`CSR_STO]})
        2'b10: begin
          if (mode_ff != ctl_pkg::master_receive_state) begin
            launch = 1'b1;
            l_start = 1'b1;
            l_byte = 1'b1;
          end
        end
        2'b01: begin
          if (mode_ff != ctl_pkg::slave_receive_state) begin
            launch = 1'b1;
            l_stop = 1'b1;
          end
        end
        2'b11: begin
          if (mode_ff != ctl_pkg::slave_receive_state) begin
            launch = 1'b1;
            l_stop = 1'b1;
            l_start = 1'b1;
            l_byte = 1'b1;
          end
        end
        default: begin
          launch = 1'b0;
        end
      endcase
    end else if (wr_pulse && sel == ctl_pkg::sel_data && eso_ff && !busy_ff
                 && mode_ff == ctl_pkg::master_transmit_state) begin
      launch = 1'b1;
      l_byte = 1'b1;
    end else if (rd_pulse && sel == ctl_pkg::sel_data && eso_ff && !busy_ff
                 && mode_ff == ctl_pkg::master_receive_state) begin
      launch = 1'b1;
      l_byte = 1'b1;
      l_rx = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mode_ff <= ctl_pkg::slave_receive_state;
    end else if (launch && l_start) begin
      mode_ff <= shift_data_ff[0] ? ctl_pkg::master_receive_state
                                  : ctl_pkg::master_transmit_state;
    end else if (launch && l_stop) begin
      mode_ff <= ctl_pkg::slave_receive_state;
    end
  end

  // ----------------------------------------
  // request to the link domain
  // ----------------------------------------
  // payload is held still while busy, so the link samples it after the toggle settles
  logic req_tgl_ff, rq_stop_ff, rq_start_ff, rq_byte_ff, rq_rx_ff, rq_ack_ff;
  logic [7:0] rq_data_ff;
  logic [7:0] lk_rx_ff;
  logic lk_lrb_ff, done_tgl_ff;
  logic done_s1_ff, done_s2_ff, done_s3_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      req_tgl_ff <= 1'b0;
      rq_stop_ff <= 1'b0;
      rq_start_ff <= 1'b0;
      rq_byte_ff <= 1'b0;
      rq_rx_ff <= 1'b0;
      rq_ack_ff <= 1'b0;
      rq_data_ff <= `RST_BYTE;
    end else if (launch) begin
      req_tgl_ff <= ~req_tgl_ff;
      rq_stop_ff <= l_stop;
      rq_start_ff <= l_start;
      rq_byte_ff <= l_byte;
      rq_rx_ff <= l_rx;
      rq_ack_ff <= ack_ff;
      rq_data_ff <= (wr_pulse && sel == ctl_pkg::sel_data) ? f_data : shift_data_ff;
    end
  end

  // reset is stretched so that a short pulse still spans several link clock edges
  logic [3:0] lrst_hold_ff;
  logic lrst_src_ff;
  always_ff @(posedge clock) begin
    if (rst) begin
      lrst_hold_ff <= `LRST_HOLD;
      lrst_src_ff <= 1'b1;
    end else begin
      if (lrst_hold_ff != 4'h0) begin
        lrst_hold_ff <= lrst_hold_ff - 4'h1;
      end
      lrst_src_ff <= (lrst_hold_ff != 4'h0);
    end
  end

  // the done toggle is unknown until the link side has seen its reset
  always_ff @(posedge clock) begin
    if (rst || lrst_src_ff) begin
      done_s1_ff <= 1'b0;
      done_s2_ff <= 1'b0;
      done_s3_ff <= 1'b0;
    end else begin
      done_s1_ff <= done_tgl_ff;
      done_s2_ff <= done_s1_ff;
      done_s3_ff <= done_s2_ff;
    end
  end
  assign done_pulse = done_s2_ff ^ done_s3_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      busy_ff <= 1'b0;
    end else if (launch) begin
      busy_ff <= 1'b1;
    end else if (done_pulse) begin
      busy_ff <= 1'b0;
    end
  end

  // read buffer and transmit byte share one register
  always_ff @(posedge clock) begin
    if (rst) begin
      shift_data_ff <= `RST_BYTE;
    end else if (done_pulse && rq_rx_ff) begin
      shift_data_ff <= lk_rx_ff;
    end else if (wr_pulse && sel == ctl_pkg::sel_data) begin
      shift_data_ff <= f_data;
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  logic pin_ff, uninit_ff, sts_ff, ber_ff, lrb_ff, aas_ff, lab_ff, bus_free_ff;
  logic pin_wr;
  assign pin_wr = wr_pulse && sel == ctl_pkg::sel_ctrl;

  always_ff @(posedge clock) begin
    if (rst) begin
      pin_ff <= `RST_PIN;
    end else if (done_pulse && rq_byte_ff) begin
      pin_ff <= 1'b0;
    end else if (launch) begin
      pin_ff <= 1'b1;
    end else if (pin_wr) begin
      pin_ff <= f_data[`CSR_PIN];
    end
  end

  // flags that this block does not generate stay at their cleared value
  always_ff @(posedge clock) begin
    if (rst) begin
      sts_ff <= 1'b0;
      ber_ff <= 1'b0;
      aas_ff <= 1'b0;
      lab_ff <= 1'b0;
      lrb_ff <= 1'b0;
    end else if (done_pulse && rq_byte_ff) begin
      lrb_ff <= lk_lrb_ff; // byte result wins over a clear in the same cycle
    end else if (pin_wr && f_data[`CSR_PIN]) begin
      sts_ff <= 1'b0;
      ber_ff <= 1'b0;
      aas_ff <= 1'b0;
      lab_ff <= 1'b0;
      lrb_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bus_free_ff <= `RST_BUS_FREE;
    end else if (launch && l_start) begin
      bus_free_ff <= 1'b0;
    end else if (launch && l_stop) begin
      bus_free_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      uninit_ff <= `RST_UNINIT;
    end else if (wr_pulse && sel == ctl_pkg::sel_own) begin
      uninit_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // host read port and interrupt
  // ----------------------------------------
  logic irq_acknowledge_n_cyc;
  logic [7:0] rdata;
  assign irq_acknowledge_n_cyc = ~f_irq_acknowledge_n_n & ~es1_ff & eni_ff;

  always_comb begin
    rdata = 8'h00;
    if (irq_acknowledge_n_cyc) begin
      rdata = irq_vector_ff;
    end else if (sel == ctl_pkg::sel_ctrl && eso_ff) begin
      rdata = {pin_ff, uninit_ff, sts_ff, ber_ff, lrb_ff, aas_ff, lab_ff, bus_free_ff};
    end else if (sel == ctl_pkg::sel_ctrl) begin
      rdata = {pin_ff, 3'h0, eni_ff, sta_ff, sto_ff, ack_ff};
    end else if (sel == ctl_pkg::sel_own) begin
      rdata = own_address_ff;
    end else if (sel == ctl_pkg::sel_vec) begin
      rdata = irq_vector_ff;
    end else if (sel == ctl_pkg::sel_clk) begin
      rdata = clock_config_ff;
    end else if (sel == ctl_pkg::sel_data) begin
      rdata = shift_data_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
      irq_n <= 1'b1;
    end else begin
      data_out <= rdata;
      data_oe <= rd_act | irq_acknowledge_n_cyc;
      irq_n <= ~(eni_ff & ~pin_ff);
    end
  end

  // ----------------------------------------
  // link domain: bus sequencer on link_clk
  // ----------------------------------------
  logic lrst_s1_ff, lrst_ff, rq_s1_ff, rq_s2_ff, rq_s3_ff;
  logic sda_s1_ff, sda_s2_ff, sda_s3_ff, sda_f_ff;
  ctl_pkg::link_t lst_ff;
  logic [2:0] ph_ff;
  logic [3:0] bit_ff;
  logic [7:0] sh_ff;

  always_ff @(posedge link_clk) begin
    lrst_s1_ff <= lrst_src_ff;
    lrst_ff <= lrst_s1_ff;
    sda_s1_ff <= sda_in;
    sda_s2_ff <= sda_s1_ff;
    sda_s3_ff <= sda_s2_ff;
  end

  always_ff @(posedge link_clk) begin
    if (lrst_ff) begin
      rq_s1_ff <= 1'b0;
      rq_s2_ff <= 1'b0;
      rq_s3_ff <= 1'b0;
      sda_f_ff <= 1'b1;
    end else begin
      rq_s1_ff <= req_tgl_ff;
      rq_s2_ff <= rq_s1_ff;
      rq_s3_ff <= rq_s2_ff;
      if (sda_s2_ff == sda_s3_ff) begin
        sda_f_ff <= sda_s3_ff;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst_ff) begin
      lst_ff <= ctl_pkg::l_idle;
      ph_ff <= 3'h0;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      lk_rx_ff <= 8'h00;
      lk_lrb_ff <= 1'b0;
      done_tgl_ff <= 1'b0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      ph_ff <= ph_ff + 3'h1;
      case (lst_ff)
        ctl_pkg::l_idle: begin
          ph_ff <= 3'h0;
          bit_ff <= 4'h0;
          sh_ff <= rq_data_ff;
          if (rq_s2_ff ^ rq_s3_ff) begin
            lst_ff <= rq_stop_ff ? ctl_pkg::l_stop
                    : (rq_start_ff ? ctl_pkg::l_start : ctl_pkg::l_bit);
          end
        end
        ctl_pkg::l_stop: begin
          // data low under low clock, clock up, then data up
          if (ph_ff < `PH_SCL_HIGH_FIRST) begin
            scl_oe <= 1'b1;
            sda_oe <= 1'b1;
          end else if (ph_ff < `PH_SCL_LOW_AGAIN) begin
            scl_oe <= 1'b0;
          end else begin
            sda_oe <= 1'b0;
          end
          if (ph_ff == `PH_LAST) begin
            lst_ff <= rq_start_ff ? ctl_pkg::l_start : ctl_pkg::l_end;
          end
        end
        ctl_pkg::l_start: begin
          // data high, clock up, data falls, clock falls
          if (ph_ff < `PH_SCL_HIGH_FIRST) begin
            sda_oe <= 1'b0;
          end else if (ph_ff < `PH_SAMPLE) begin
            scl_oe <= 1'b0;
          end else if (ph_ff < `PH_SCL_LOW_AGAIN) begin
            sda_oe <= 1'b1;
          end else begin
            scl_oe <= 1'b1;
          end
          if (ph_ff == `PH_LAST) begin
            lst_ff <= ctl_pkg::l_bit;
          end
        end
        ctl_pkg::l_bit: begin
          if (ph_ff < `PH_SCL_HIGH_FIRST) begin
            scl_oe <= 1'b1;
            if (bit_ff == `BIT_ACK) begin
              sda_oe <= rq_rx_ff & rq_ack_ff;
            end else begin
              sda_oe <= ~rq_rx_ff & ~sh_ff[7];
            end
          end else if (ph_ff < `PH_SCL_LOW_AGAIN) begin
            scl_oe <= 1'b0;
          end else begin
            scl_oe <= 1'b1;
          end
          if (ph_ff == `PH_SAMPLE) begin
            if (bit_ff == `BIT_ACK) begin
              lk_lrb_ff <= sda_f_ff;
            end else begin
              sh_ff <= {sh_ff[6:0], sda_f_ff};
            end
          end
          if (ph_ff == `PH_LAST) begin
            bit_ff <= bit_ff + 4'h1;
            if (bit_ff == `BIT_ACK) begin
              lst_ff <= ctl_pkg::l_end;
            end
          end
        end
        ctl_pkg::l_end: begin
          // clock is kept low after a byte so the peer waits for the host
          lk_rx_ff <= sh_ff;
          sda_oe <= sda_oe & ~rq_stop_ff;
          done_tgl_ff <= ~done_tgl_ff;
          lst_ff <= ctl_pkg::l_idle;
        end
        default: begin
          lst_ff <= ctl_pkg::l_idle;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst_ff) begin
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: i2c_ctl_sva.sv
// assertion checker for the command and decode block
`timescale 1ns/10ps
`default_nettype none
module i2c_ctl_sva (
  input wire logic clock,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic register_select_pin,
  input wire logic irq_acknowledge_n,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic irq_n,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic scl_out,
  input wire logic scl_oe
);
  // ----------------
  // host side
  // ----------------
  a_reset_host: assert property (@(posedge clock) disable iff (rst)
    $fell(rst) |-> irq_n && !data_oe && data_out == 8'h00) else $error("host outputs not idle after reset");
  a_oe_on_read: assert property (@(posedge clock) disable iff (rst)
    (!cs_n && !rd_n) [*7] |-> data_oe) else $error("read not answered");
  a_oe_idle: assert property (@(posedge clock) disable iff (rst)
    ((rd_n || cs_n) && irq_acknowledge_n) [*7] |-> !data_oe) else $error("data bus driven while idle");
  // ----------------
  // link side
  // ----------------
  // link outputs are valid only once the stretched reset has crossed over
  int unsigned settle_cnt;
  logic lk_quiet;
  always_ff @(posedge clock) begin
    if (rst) begin
      settle_cnt <= 40;
    end else if (settle_cnt != 0) begin
      settle_cnt <= settle_cnt - 1;
    end
  end
  assign lk_quiet = rst || (settle_cnt != 0);
  a_reset_link: assert property (@(posedge link_clk) disable iff (lk_quiet)
    $fell(lk_quiet) |-> !sda_oe && !scl_oe) else $error("link lines pulled after reset");
  a_sda_open_drain: assert property (@(posedge link_clk) disable iff (lk_quiet)
    sda_out == 1'b0) else $error("sda driven high");
  a_scl_open_drain: assert property (@(posedge link_clk) disable iff (lk_quiet)
    scl_out == 1'b0) else $error("scl driven high");
  // a shortened high phase would break peers that sample late
  a_scl_high_time: assert property (@(posedge link_clk) disable iff (lk_quiet)
    $fell(scl_oe) |-> (!scl_oe) [*4]) else $error("scl high phase too short");
  a_scl_low_time: assert property (@(posedge link_clk) disable iff (lk_quiet)
    $rose(scl_oe) |=> scl_oe) else $error("scl low phase too short");
  c_irq: cover property (@(posedge clock) disable iff (rst) $fell(irq_n));
  c_ack: cover property (@(posedge clock) disable iff (rst) $rose(data_oe) && !irq_acknowledge_n);
  c_sda: cover property (@(posedge link_clk) disable iff (rst) $rose(sda_oe));
endmodule
`default_nettype wire

// file: i2c_peer_model.sv
// behavioural bus peer: acks address and written bytes, sends a fixed byte on reads
`timescale 1ns/10ps
`default_nettype none
module i2c_peer_model #(
  parameter logic [7:0] RD_BYTE = 8'h96
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe,
  output logic [7:0] rx_byte,
  output int start_cnt,
  output logic ack_seen
);
  // ----------------
  // frame tracking
  // ----------------
  logic [7:0] sh;
  int cnt;
  logic act;
  logic rdm;
  logic first;
  initial begin
    sda_oe = 0; cnt = 0; act = 0; rdm = 0; first = 0; start_cnt = 0; rx_byte = 8'h00; sh = 8'h00;
    ack_seen = 1'b1;
  end
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1; first = 1; cnt = 0; rdm = 0; sda_oe = 0; start_cnt++;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    act = 0;
    sda_oe = 0;
  end
  always @(posedge scl) if (act && cnt < 8) begin
    sh = {sh[6:0], sda};
    cnt++;
  end
  // level in the acknowledge slot of a data byte that the peer sent
  always @(posedge scl) if (act && cnt == 9 && rdm && !first) ack_seen = sda;
  // released line floats to the pull-up level, never holds the old bit
  always @(negedge scl) if (act) begin
    if (cnt == 9) begin
      cnt = 0; first = 0;
    end
    if (cnt == 8) begin
      rx_byte = sh;
      if (first) rdm = sh[0];
      sda_oe = first || !rdm;
      cnt = 9;
    end else
      sda_oe = rdm && !RD_BYTE[7-cnt];
  end
endmodule
`default_nettype wire

// file: i2c_controller_command_decode_tb_top.sv
// self-checking bench for the command and decode block
`timescale 1ns/10ps
`default_nettype none
module i2c_controller_command_decode_tb_top;
  // ----------------
  // signals
  // ----------------
  logic clock, rst, link_clk, cs_n, rd_n, wr_n, register_select_pin, irq_acknowledge_n;
  logic [7:0] data_in, data_out, rx_byte;
  logic data_oe, irq_n, sda_out, sda_oe, scl_out, scl_oe, peer_oe, ack_seen;
  wire logic sda_w = !(sda_oe || peer_oe);
  wire logic scl_w = !scl_oe;
  int err_count = 0;
  int samples_checked = 0;
  int start_cnt;
  i2c_controller_command_decode DUT (.clock(clock), .rst(rst), .link_clk(link_clk), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .register_select_pin(register_select_pin),
    .irq_acknowledge_n(irq_acknowledge_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .irq_n(irq_n), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe));
  i2c_peer_model peer (.scl(scl_w), .sda(sda_w), .sda_oe(peer_oe), .rx_byte(rx_byte), .start_cnt(start_cnt),
    .ack_seen(ack_seen));
  initial begin
    clock = 0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    link_clk = 0;
    #7;
    forever #40 link_clk = ~link_clk;
  end
  // ----------------
  // shared tasks
  // ----------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // strobes held 7 clocks: the pin filter needs 3-4 and the answer one more
  task automatic acc(input logic w, input logic a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clock);
    cs_n = 0; wr_n = !w; rd_n = w; register_select_pin = a; data_in = d;
    repeat (7) @(negedge clock);
    q = data_out;
    cs_n = 1; wr_n = 1; rd_n = 1;
    repeat (6) @(negedge clock);
  endtask
  task automatic poll(input int b, input logic v);
    int n;
    logic [7:0] s;
    for (n = 0; n < 80; n++) begin
      acc(0, 1, 8'h00, s);
      if (s[b] === v) break;
    end
    if (n == 80) begin
      err_count++;
      $display("CHECK FAILED %0t status wait ran out", $time);
      conclude();
    end
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_setup();
    logic [7:0] s;
    acc(0, 1, 8'h00, s); chk(s, 8'h80);
    acc(1, 1, 8'h80, s); acc(1, 0, 8'h55, s); acc(0, 0, 8'h00, s); chk(s, 8'h55);
    acc(1, 1, 8'h90, s); acc(1, 0, 8'hA5, s); acc(0, 0, 8'h00, s); chk(s, 8'hA5);
    acc(1, 1, 8'hA0, s); acc(1, 0, 8'h1C, s); acc(0, 0, 8'h00, s); chk(s, 8'h1C);
    acc(1, 1, 8'h08, s); chk({7'h00, irq_n}, 8'h00);
    acc(0, 1, 8'h00, s); chk(s, 8'h08);
    irq_acknowledge_n = 0;
    repeat (7) @(negedge clock);
    chk({7'h00, data_oe}, 8'h01);
    chk(data_out, 8'hA5);
    irq_acknowledge_n = 1;
    repeat (6) @(negedge clock);
    acc(1, 1, 8'h84, s); acc(0, 1, 8'h00, s); chk(s, 8'h84);
    repeat (60) @(negedge clock);
    chk({6'h00, scl_oe, sda_oe}, 8'h00);
    chk(start_cnt[7:0], 8'h00);
    acc(1, 1, 8'h00, s); chk({7'h00, irq_n}, 8'h01);
  endtask
  task automatic t_enable();
    logic [7:0] s;
    acc(1, 1, 8'hC1, s);
    acc(0, 1, 8'h00, s); chk(s, 8'h81);
    acc(1, 1, 8'hD1, s); acc(0, 0, 8'h00, s); chk(s, 8'hA5);
    acc(1, 1, 8'hC1, s);
  endtask
  task automatic t_write();
    logic [7:0] s;
    acc(1, 0, 8'hA0, s);
    acc(1, 1, 8'hC5, s);
    poll(7, 1'b0);
    chk(rx_byte, 8'hA0);
    acc(0, 1, 8'h00, s); chk(s & 8'h09, 8'h00);
    acc(1, 0, 8'h3C, s);
    poll(7, 1'b0);
    chk(rx_byte, 8'h3C);
    acc(1, 1, 8'hC7, s);
    poll(7, 1'b0);
    chk(start_cnt[7:0], 8'h02);
  endtask
  task automatic t_read_stop();
    logic [7:0] s;
    acc(1, 0, 8'hA1, s);
    poll(7, 1'b0);
    acc(1, 1, 8'hC5, s);
    poll(7, 1'b0);
    chk(start_cnt[7:0], 8'h03);
    chk(rx_byte, 8'hA1);
    acc(0, 0, 8'h00, s);
    poll(7, 1'b0);
    chk({7'h00, ack_seen}, 8'h00);
    acc(1, 1, 8'hC4, s);
    acc(0, 0, 8'h00, s); chk(s, 8'h96);
    poll(7, 1'b0);
    chk({7'h00, ack_seen}, 8'h01);
    acc(0, 1, 8'h00, s); chk(s & 8'h08, 8'h08);
    acc(1, 1, 8'hC2, s);
    poll(0, 1'b1);
    acc(0, 1, 8'h00, s); chk(s, 8'h81);
    acc(0, 0, 8'h00, s); chk(s, 8'h96);
    chk({6'h00, scl_oe, sda_oe}, 8'h00);
  endtask
  task automatic t_nop();
    logic [7:0] s;
    acc(1, 1, 8'hC3, s);
    acc(1, 1, 8'hC1, s);
    repeat (100) @(negedge clock);
    chk(start_cnt[7:0], 8'h03);
    chk({6'h00, scl_oe, sda_oe}, 8'h00);
    acc(1, 1, 8'hF1, s); acc(0, 0, 8'h00, s); chk(s, 8'h96);
    acc(1, 1, 8'hA0, s); acc(0, 0, 8'h00, s); chk(s, 8'h1C);
  endtask
  // ----------------
  // main sequence
  // ----------------
  initial begin
    cs_n = 1; rd_n = 1; wr_n = 1; register_select_pin = 0; irq_acknowledge_n = 1; data_in = 8'h00;
    rst = 1;
    // the design stretches reset for its link side, so a short pulse is enough
    repeat (2) @(negedge clock);
    rst = 0;
    repeat (2) @(negedge clock);
    t_setup();
    t_enable();
    t_write();
    t_read_stop();
    t_nop();
    conclude();
  end
endmodule
bind i2c_controller_command_decode i2c_ctl_sva u_sva (.clock(clock), .rst(rst), .link_clk(link_clk),
  .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .register_select_pin(register_select_pin),
  .irq_acknowledge_n(irq_acknowledge_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
  .irq_n(irq_n), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe));
`default_nettype wire
